// *** hdl/bst_pkg.sv ***
package bst_pkg;
  // Instruction register width and identification width
  localparam int IR_W = 4;
  localparam int ID_W = 32;
  // Identification field positions
  localparam int ID_VER_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MFR_LSB = 1;
  // Public instruction codes; any other code selects the bypass path
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_SAMPLE = 4'h1;
  localparam logic [3:0] IR_IDCODE = 4'h2;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  // Pattern loaded in instruction capture, low bits 01
  localparam logic [3:0] IR_CAPT = 4'h1;
  // Bypass stage value loaded in data capture
  localparam logic BYP_CAPT = 1'b0;
  // Identification defaults; values are arbitrary
  localparam logic [3:0] ID_VER_DEF = 4'h3;
  localparam logic [15:0] ID_PART_DEF = 16'hA5C3;
  localparam logic [10:0] ID_MFR_DEF = 11'h2B6;
  // Sixteen controller states
  typedef enum logic [3:0] {
    S_TLR, S_RTI, S_SELDR, S_CAPDR, S_SHDR, S_EX1DR, S_PSDR, S_EX2DR, S_UPDR,
    S_SELIR, S_CAPIR, S_SHIR, S_EX1IR, S_PSIR, S_EX2IR, S_UPIR
  } bst_tap_t;
endpackage

// *** hdl/bst_tap.sv ***
// Functional notes
// - Mode select sampled each rising test clock
// - Test data input captured on rising edge
// - Test output changes only on falling edges
// - Output driver released unless shifting
// - Undriven select, data, reset read high; this module has no pull-ups, they sit outside it
// - Test reset clears the scan structure
// - Four-bit instruction register, public instructions
// - Instruction bits shift only in shift-IR
// - Instruction selects active data register path
// - Input routed to instruction or data register
// - Selected register contents shifted out serially
// - Test clock independent; core undisturbed
// - Exactly three data registers exist
// - Boundary chain wraps core inputs and outputs
// - Bypass is one flip-flop stage
// - Identification word fields and bit zero one
`timescale 1ns/1ps
module bst_tap
  import bst_pkg::*;
#(
  parameter int BS_IN = 4,
  parameter int BS_OUT = 4,
  parameter logic [3:0] ID_VER = ID_VER_DEF,
  parameter logic [15:0] ID_PART = ID_PART_DEF,
  parameter logic [10:0] ID_MFR = ID_MFR_DEF
) (
  // System clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Test access pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  // Device pins and core side
  input wire logic [BS_IN-1:0] pin_in,
  output logic [BS_IN-1:0] core_in,
  input wire logic [BS_OUT-1:0] core_out,
  output logic [BS_OUT-1:0] pin_out
);
  localparam int BSL = BS_IN + BS_OUT;
  localparam logic [ID_W-1:0] ID_VALUE = {ID_VER, ID_PART, ID_MFR, 1'b1};

  function automatic logic sel_bs(input logic [IR_W-1:0] ir);
    return (ir == IR_EXTEST) || (ir == IR_SAMPLE);
  endfunction

  function automatic logic sel_id(input logic [IR_W-1:0] ir);
    return ir == IR_IDCODE;
  endfunction

  bst_tap_t state_ff;
  bst_tap_t nxt_state;
  logic [IR_W-1:0] ir_sh_ff;
  logic [IR_W-1:0] ir_ff;
  logic bypass_ff;
  logic [ID_W-1:0] idsh_ff;
  logic [BSL-1:0] bs_sh_ff;
  logic [BS_OUT-1:0] bs_upd_ff;
  logic ext_t_ff;
  logic [BS_IN-1:0] pin_t1_ff, pin_t2_ff;
  logic [BS_OUT-1:0] core_t1_ff, core_t2_ff;
  logic tdo_ff, tdo_oe_ff;
  logic [BS_IN-1:0] pin_c1_ff, pin_c2_ff;
  logic ext_c1_ff, ext_c2_ff;
  logic upd_tgl_ff;
  logic tgl_c1_ff, tgl_c2_ff, tgl_c3_ff;
  logic [BS_OUT-1:0] upd_cap_ff;
  logic tdo_hold_ff;
  logic [BS_OUT-1:0] pin_out_ff;
  logic shifting;
  logic dr_out;

  // Controller sequencing from mode select; pins resolve pull-ups outside
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_TLR: nxt_state = tms ? S_TLR : S_RTI;
      S_RTI: nxt_state = tms ? S_SELDR : S_RTI;
      S_SELDR: nxt_state = tms ? S_SELIR : S_CAPDR;
      S_CAPDR: nxt_state = tms ? S_EX1DR : S_SHDR;
      S_SHDR: nxt_state = tms ? S_EX1DR : S_SHDR;
      S_EX1DR: nxt_state = tms ? S_UPDR : S_PSDR;
      S_PSDR: nxt_state = tms ? S_EX2DR : S_PSDR;
      S_EX2DR: nxt_state = tms ? S_UPDR : S_SHDR;
      S_UPDR: nxt_state = tms ? S_SELDR : S_RTI;
      S_SELIR: nxt_state = tms ? S_TLR : S_CAPIR;
      S_CAPIR: nxt_state = tms ? S_EX1IR : S_SHIR;
      S_SHIR: nxt_state = tms ? S_EX1IR : S_SHIR;
      S_EX1IR: nxt_state = tms ? S_UPIR : S_PSIR;
      S_PSIR: nxt_state = tms ? S_EX2IR : S_PSIR;
      S_EX2IR: nxt_state = tms ? S_UPIR : S_SHIR;
      S_UPIR: nxt_state = tms ? S_SELDR : S_RTI;
      default: nxt_state = S_TLR;
    endcase
  end

  // State register; test reset forces the reset state at once
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      state_ff <= S_TLR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Instruction shift stage and current instruction
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_sh_ff <= IR_CAPT;
      ir_ff <= IR_IDCODE;
    end else begin
      case (state_ff)
        S_TLR: ir_ff <= IR_IDCODE;
        S_CAPIR: ir_sh_ff <= IR_CAPT;
        S_SHIR: ir_sh_ff <= {tdi, ir_sh_ff[IR_W-1:1]};
        S_UPIR: ir_ff <= ir_sh_ff;
        default: ir_sh_ff <= ir_sh_ff;
      endcase
    end
  end

  // Data registers: bypass, identification, boundary chain only
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      bypass_ff <= BYP_CAPT;
      idsh_ff <= '0;
      bs_sh_ff <= '0;
    end else if (state_ff == S_CAPDR) begin
      bypass_ff <= BYP_CAPT;
      idsh_ff <= ID_VALUE;
      bs_sh_ff <= {pin_t2_ff, core_t2_ff};
    end else if (state_ff == S_SHDR) begin
      // Only the path chosen by the instruction moves
      if (sel_bs(ir_ff)) begin
        bs_sh_ff <= {tdi, bs_sh_ff[BSL-1:1]};
      end else if (sel_id(ir_ff)) begin
        idsh_ff <= {tdi, idsh_ff[ID_W-1:1]};
      end else begin
        bypass_ff <= tdi;
      end
    end
  end

  // Output cell update stage; loaded by both extest and sample/preload
  // A toggle marks each load so the system clock side knows when the word is settled
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      bs_upd_ff <= '0;
      upd_tgl_ff <= 1'b0;
      ext_t_ff <= 1'b0;
    end else begin
      if (state_ff == S_UPDR && sel_bs(ir_ff)) begin
        bs_upd_ff <= bs_sh_ff[BS_OUT-1:0];
        upd_tgl_ff <= ~upd_tgl_ff;
      end
      ext_t_ff <= (ir_ff == IR_EXTEST);
    end
  end

  // Pin and core levels brought into the test clock domain
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      pin_t1_ff <= '0;
      pin_t2_ff <= '0;
      core_t1_ff <= '0;
      core_t2_ff <= '0;
    end else begin
      pin_t1_ff <= pin_in;
      pin_t2_ff <= pin_t1_ff;
      core_t1_ff <= core_out;
      core_t2_ff <= core_t1_ff;
    end
  end

  // Serial output source for the current scan
  assign shifting = (state_ff == S_SHIR) || (state_ff == S_SHDR);
  assign dr_out = sel_bs(ir_ff) ? bs_sh_ff[0] : (sel_id(ir_ff) ? idsh_ff[0] : bypass_ff);

  // Falling edge launch gives the controller half a period of setup
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      tdo_ff <= (state_ff == S_SHIR) ? ir_sh_ff[0] : dr_out;
      tdo_oe_ff <= shifting;
    end
  end

  // Test output level as left by each rising edge; the falling-edge check
  // compares against it, since only the falling edge may move the output
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tdo_hold_ff <= 1'b0;
    end else begin
      tdo_hold_ff <= tdo_ff;
    end
  end

  // Functional domain: pins, extest flag and the update toggle cross by two flops
  // The update word is not synchronised bit by bit: it was loaded with the toggle
  // and stays put until the next update, so it is settled once the toggle arrives
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_c1_ff <= '0;
      pin_c2_ff <= '0;
      ext_c1_ff <= 1'b0;
      ext_c2_ff <= 1'b0;
      tgl_c1_ff <= 1'b0;
      tgl_c2_ff <= 1'b0;
      tgl_c3_ff <= 1'b0;
    end else begin
      pin_c1_ff <= pin_in;
      pin_c2_ff <= pin_c1_ff;
      ext_c1_ff <= ext_t_ff;
      ext_c2_ff <= ext_c1_ff;
      tgl_c1_ff <= upd_tgl_ff;
      tgl_c2_ff <= tgl_c1_ff;
      tgl_c3_ff <= tgl_c2_ff;
    end
  end

  // Update word taken once its toggle is seen; a reset here clears it, and it is retaken only if upd_tgl_ff stands high
  // Limitation: two updates closer than three system clocks would merge into one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      upd_cap_ff <= '0;
    end else if (tgl_c2_ff != tgl_c3_ff) begin
      upd_cap_ff <= bs_upd_ff;
    end
  end

  // Core keeps its own path unless extest owns the output pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_out_ff <= '0;
    end else begin
      pin_out_ff <= ext_c2_ff ? upd_cap_ff : core_out;
    end
  end

  assign tdo = tdo_ff;
  assign tdo_oe = tdo_oe_ff;
  assign core_in = pin_c2_ff;
  assign pin_out = pin_out_ff;

  // Checks on the test clock domain, plus the extest pin check on the system clock
  tms_reset_a: assert property (@(posedge tck) disable iff (!trst_n)
    tms [*5] |=> state_ff == S_TLR) else $error("five high TMS did not reach reset");
  ir_capture_a: assert property (@(posedge tck) disable iff (!trst_n)
    state_ff == S_CAPIR |=> ir_sh_ff == IR_CAPT) else $error("IR capture pattern");
  ir_shift_a: assert property (@(posedge tck) disable iff (!trst_n)
    state_ff == S_SHIR |=> ir_sh_ff[IR_W-1] == $past(tdi)) else $error("IR shift input");
  ir_reset_a: assert property (@(posedge tck) disable iff (!trst_n)
    state_ff == S_TLR |=> ir_ff == IR_IDCODE) else $error("reset did not select ID");
  ir_update_a: assert property (@(posedge tck) disable iff (!trst_n)
    state_ff == S_UPIR |=> ir_ff == $past(ir_sh_ff)) else $error("IR update value");
  bypass_path_a: assert property (@(posedge tck) disable iff (!trst_n)
    state_ff == S_SHDR && ir_ff == IR_BYPASS ##1 state_ff == S_SHDR |=>
    tdo_ff == $past(tdi)) else $error("bypass one-stage path");
  id_capture_a: assert property (@(posedge tck) disable iff (!trst_n)
    state_ff == S_CAPDR && sel_id(ir_ff) |=> idsh_ff == ID_VALUE && idsh_ff[0])
    else $error("ID capture value");
  tdo_release_a: assert property (@(posedge tck) disable iff (!trst_n)
    tdo_oe_ff == shifting) else $error("TDO driver state differs from shift state");
  tdo_ir_a: assert property (@(posedge tck) disable iff (!trst_n)
    state_ff == S_SHIR |-> tdo_ff == ir_sh_ff[0]) else $error("IR serial out");
  extest_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    ext_c2_ff |=> pin_out_ff == $past(upd_cap_ff)) else $error("extest pin drive");
  // Edge, capture and hold checks; the edge check is backed by helper state
  tdo_edge_a: assert property (@(negedge tck) disable iff (!trst_n)
    tdo_ff == tdo_hold_ff) else $error("test output moved on a rising edge");
  byp_capture_a: assert property (@(posedge tck) disable iff (!trst_n)
    state_ff == S_CAPDR |=> bypass_ff == BYP_CAPT) else $error("bypass capture value");
  id_fields_a: assert property (@(posedge tck) disable iff (!trst_n)
    state_ff == S_CAPDR |=> idsh_ff[ID_W-1:ID_VER_LSB] == ID_VER
    && idsh_ff[ID_VER_LSB-1:ID_PART_LSB] == ID_PART
    && idsh_ff[ID_PART_LSB-1:ID_MFR_LSB] == ID_MFR) else $error("ID field layout");
  ir_hold_a: assert property (@(posedge tck) disable iff (!trst_n)
    !(state_ff inside {S_CAPIR, S_SHIR}) |=> $stable(ir_sh_ff))
    else $error("IR shift stage moved outside its scan");
  dr_path_a: assert property (@(posedge tck) disable iff (!trst_n)
    state_ff == S_SHDR && sel_id(ir_ff) |=> $stable(bs_sh_ff) && $stable(bypass_ff))
    else $error("unselected data register moved");

  // Main scenarios
  cov_ir_scan: cover property (@(posedge tck) disable iff (!trst_n)
    state_ff == S_SHIR ##1 state_ff == S_EX1IR ##1 state_ff == S_UPIR);
  cov_id_scan: cover property (@(posedge tck) disable iff (!trst_n)
    state_ff == S_SHDR && sel_id(ir_ff));
  cov_bypass: cover property (@(posedge tck) disable iff (!trst_n)
    state_ff == S_SHDR && ir_ff == IR_BYPASS);
  cov_extest: cover property (@(posedge clk) disable iff (sys_rst) ext_c2_ff);
  cov_update_cross: cover property (@(posedge clk) disable iff (sys_rst)
    tgl_c2_ff != tgl_c3_ff);
endmodule

// *** test/bst_ctl_model.sv ***
`timescale 1ns/1ps
module bst_ctl_model (
  // Test access pins
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // Port held in reset at power-up; released pins rest at their pull-up level
  initial begin
    trst_n = 1'b0;
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // Pulse test reset with one test clock inside it, so the port clears even
  // when the pin already sat low from power-up and gives no falling edge
  task automatic reset_port;
    trst_n = 1'b0;
    #7.5 tck = 1'b1;
    #7.5 tck = 1'b0;
    #5 trst_n = 1'b1;
    #10;
  endtask
  // One test clock: drive after the fall, sample output just before the rise
  task automatic step(input logic m, input logic d, output logic q, output logic oe);
    tms = m;
    tdi = d;
    #7.5 q = tdo;
    oe = tdo_oe;
    tck = 1'b1;
    #7.5 tck = 1'b0;
  endtask
  // Five ones reach the reset state from anywhere, then idle
  task automatic idle;
    logic q, oe;
    repeat (5) step(1'b1, 1'b1, q, oe);
    step(1'b0, 1'b1, q, oe);
  endtask
  // Full scan from idle back to idle, LSB first
  task automatic scan(input logic ir, input logic [32:0] din, input int n,
                      output logic [32:0] dout, output logic oe_all);
    logic q, oe;
    step(1'b1, 1'b1, q, oe);
    if (ir) step(1'b1, 1'b1, q, oe);
    step(1'b0, 1'b1, q, oe);
    step(1'b0, 1'b1, q, oe);
    dout = '0;
    oe_all = 1'b1;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q, oe);
      dout[i] = q;
      oe_all &= oe;
    end
    step(1'b1, 1'b1, q, oe);
    step(1'b0, 1'b1, q, oe);
  endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import bst_pkg::*;
  localparam int BS_IN = 4;
  localparam int BS_OUT = 4;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic [BS_IN-1:0] pin_in = '0;
  logic [BS_IN-1:0] core_in;
  logic [BS_OUT-1:0] core_out = '0;
  logic [BS_OUT-1:0] pin_out;
  int n_errors = 0;
  int total_checks = 0;
  // System clock
  always #5 clk = ~clk;
  bst_tap #(.BS_IN(BS_IN), .BS_OUT(BS_OUT)) uut (.clk(clk), .sys_rst(sys_rst),
    .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
    .pin_in(pin_in), .core_in(core_in), .core_out(core_out), .pin_out(pin_out));
  bst_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
    .tdo_oe(tdo_oe));
  // Compare and count
  task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Identification read straight after reset, driver released when idle
  task automatic t_idcode;
    logic [32:0] o;
    logic oe;
    ctl.idle();
    ctl.scan(1'b0, '0, 32, o, oe);
    check("idcode", {1'b0, ID_VER_DEF, ID_PART_DEF, ID_MFR_DEF, 1'b1}, o);
    check("shift_oe", 33'h1, {32'h0, oe});
    check("idle_oe", 33'h0, {32'h0, tdo_oe});
  endtask
  // Bypass code and an unlisted code both give a one-stage path
  task automatic t_bypass;
    logic [3:0] codes [2] = '{IR_BYPASS, 4'h5};
    logic [32:0] o;
    logic oe;
    foreach (codes[k]) begin
      ctl.scan(1'b1, {29'h0, codes[k]}, 4, o, oe);
      check("ir_capture", {29'h0, IR_CAPT}, o);
      ctl.scan(1'b0, 33'h1_2345_6789, 33, o, oe);
      check("bypass", {32'h2345_6789, BYP_CAPT}, o);
    end
  endtask
  // Sample the boundary while the core keeps running
  task automatic t_sample;
    logic [32:0] o;
    logic oe;
    @(negedge clk);
    pin_in = 4'hA;
    core_out = 4'h6;
    repeat (4) @(negedge clk);
    ctl.scan(1'b1, {29'h0, IR_SAMPLE}, 4, o, oe);
    ctl.scan(1'b0, 33'hC3, BS_IN + BS_OUT, o, oe);
    check("sample", 33'hA6, o);
    check("core_in", {29'h0, pin_in}, {29'h0, core_in});
    check("pin_out", {29'h0, core_out}, {29'h0, pin_out});
  endtask
  // External test drives the update cells onto the output pins
  task automatic t_extest;
    logic [32:0] o;
    logic oe;
    int w;
    ctl.scan(1'b1, {29'h0, IR_EXTEST}, 4, o, oe);
    ctl.scan(1'b0, 33'h59, BS_IN + BS_OUT, o, oe);
    w = 0;
    while (pin_out !== 4'h9 && w < 30) begin
      @(negedge clk);
      w++;
    end
    check("extest_pins", 33'h9, {29'h0, pin_out});
    check("extest_core", {29'h0, pin_in}, {29'h0, core_in});
  endtask
  // Test reset and five ones both bring back the identification path
  task automatic t_reset;
    logic [32:0] o;
    logic oe;
    for (int k = 0; k < 2; k++) begin
      ctl.scan(1'b1, {29'h0, IR_BYPASS}, 4, o, oe);
      if (k == 0) ctl.reset_port();
      ctl.idle();
      ctl.scan(1'b0, '0, 32, o, oe);
      check("reset_id", {1'b0, ID_VER_DEF, ID_PART_DEF, ID_MFR_DEF, 1'b1}, o);
    end
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    ctl.reset_port();
    t_idcode();
    t_bypass();
    t_sample();
    t_extest();
    t_reset();
    give_verdict();
  end
  // Watchdog, far beyond the few microseconds the scans need
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
endmodule
